// file: rtl/scan_timing_pkg.sv
// Package for the scan clamp, auxiliary dot clock and lamp envelope timing block.
// Assumes an APB master with 32-bit data and the scan unit's line and dot strobes.
// Function
// R1 - Line clamp: skip pixels, then hold length
// R2 - Line restarts before skip: no clamp
// R3 - Origin at line start, lead-in short: none
// R4 - Clamp fall slot from bits 7:4
// R5 - Clamp rise slot from bits 3:0
// R6 - Bit 15 picks sample or aux clock
// R7 - Bit 12 shifts aux clock edge phase
// R8 - Bits 11:10 delay aux clock 0-3 units
// R9 - Bit 9 inverts, bit 8 adds guard band
// R10 - Aux clock fall 7:4, rise 3:0
// R11 - Lamp trailing edge bits 15:8, x64 pixels
// R12 - Lamp leading edge bits 7:0, x64 pixels
// R13 - Lamp edges after lead-in, per channel
// R14 - Origin set: count from line start
// R15 - Seven-bit length gives clamp pixel count
// R16 - Pixel clamp: whole line, skip ignored
// R17 - Lamp on between leading and trailing edge
// R18 - Settings readable, applied at next line
package scan_timing_pkg;

   // Register indices; byte address is four times the index
   localparam logic [29:0] IDX_CLAMP_EDGE = 30'h01ff88ab;
   localparam logic [29:0] IDX_LAMP0 = 30'h01ff88ad;
   localparam logic [29:0] IDX_LAMP1 = 30'h01ff88ae;
   localparam logic [29:0] IDX_AUX_CTRL = 30'h01ff88c4;
   localparam logic [29:0] IDX_CLAMP_SKIP = 30'h01ff88a8;
   localparam logic [29:0] IDX_CLAMP_CTRL = 30'h01ff88a6;

   // Reset values
   localparam logic [15:0] RST_CLAMP_EDGE = 16'h0000;
   localparam logic [15:0] RST_LAMP = 16'h0000;
   localparam logic [15:0] RST_AUX_CTRL = 16'h0000;
   localparam logic [15:0] RST_CLAMP_SKIP = 16'h0000;
   localparam logic [15:0] RST_CLAMP_CTRL = 16'h0000;

   // Writable bit masks
   localparam logic [15:0] MASK_CLAMP_EDGE = 16'h00ff;
   localparam logic [15:0] MASK_LAMP = 16'hffff;
   localparam logic [15:0] MASK_AUX_CTRL = 16'h9fff;
   localparam logic [15:0] MASK_CLAMP_SKIP = 16'hbfff;
   localparam logic [15:0] MASK_CLAMP_CTRL = 16'h807f;

   // Field positions
   localparam int FALL_LSB = 4;
   localparam int RISE_LSB = 0;
   localparam int AUX_SELECT_BIT = 15;
   localparam int AUX_SHIFT_BIT = 12;
   localparam int AUX_DELAY_LSB = 10;
   localparam int AUX_INVERT_BIT = 9;
   localparam int AUX_GUARD_BIT = 8;
   localparam int LAMP_TRAIL_LSB = 8;
   localparam int LAMP_LEAD_LSB = 0;
   localparam int SKIP_ORIGIN_BIT = 15;
   localparam int SKIP_COUNT_LSB = 0;
   localparam int CTRL_SCHEME_BIT = 15;
   localparam int CTRL_LENGTH_LSB = 0;

   // Field widths
   localparam int SLOT_W = 4;
   localparam int SKIP_W = 14;
   localparam int LENGTH_W = 7;
   localparam int LAMP_EDGE_W = 8;
   localparam int DELAY_W = 2;

   // Lamp edge unit is 64 pixels, a shift by six
   localparam int LAMP_UNIT_SHIFT = 6;
   localparam int LAMP_CHANNELS = 2;
   localparam logic [15:0] PIX_CNT_MAX = 16'hffff;
   localparam logic [3:0] SUB_CNT_MAX = 4'hf;

endpackage

// file: rtl/aux_clock_shaper.sv
// Retimes, delays, inverts and selects the auxiliary dot clock.
// Assumes the raw clock arrives registered on mclk.
`timescale 1ns/1ps
`default_nettype none
module aux_clock_shaper (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Raw clock and settings
   input wire logic raw_clk,
   input wire logic sample_in,
   input wire logic select,
   input wire logic shift,
   input wire logic [scan_timing_pkg::DELAY_W-1:0] delay,
   input wire logic invert,
   // Pin
   output logic aux_dot_clock
);
   import scan_timing_pkg::*;

   typedef struct packed {
      logic [4:0] pipe;
      logic out;
   } shaper_t;

   shaper_t st_q;
   shaper_t st_d;
   logic [2:0] tap;
   logic tapped;

   // Tap position: delay units plus one stage for the shifted phase
   always_comb begin
      tap = {1'b0, delay} + {2'b00, shift};
      tapped = st_q.pipe[tap];
   end

   // Next state
   always_comb begin
      st_d = st_q;
      st_d.pipe = {st_q.pipe[3:0], raw_clk};
      // R6 output source select
      if (select) begin
         // R9 optional inversion
         st_d.out = tapped ^ invert;
      end else begin
         st_d.out = sample_in;
      end
   end

   // R7 R8 registered delay line
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign aux_dot_clock = st_q.out;
endmodule // aux_clock_shaper
`default_nettype wire

// file: rtl/scan_clamp_led_timing.sv
// Clamp window, auxiliary dot clock and lamp envelope generator with APB registers.
// Assumes line, dot and pixel strobes are one-cycle enables synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module scan_clamp_led_timing (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Scan unit timing
   input wire logic scan_enable,
   input wire logic line_start,
   input wire logic [15:0] line_lead_in_delay,
   input wire logic pixel_tick,
   input wire logic dot_start,
   input wire logic dot_subclock_divider,
   input wire logic sample_in,
   // Sensor and front end outputs
   output logic clamp_out,
   output logic aux_dot_clock,
   output logic [scan_timing_pkg::LAMP_CHANNELS-1:0] lamp_envelope_output
);
   import scan_timing_pkg::*;

   typedef struct packed {
      logic [15:0] clamp_edge;
      logic [15:0] lamp0;
      logic [15:0] lamp1;
      logic [15:0] aux_ctrl;
      logic [15:0] skip;
      logic [15:0] ctrl;
   } regs_t;

   typedef struct packed {
      regs_t sw;
      regs_t act;
      logic [31:0] rdata;
      logic [15:0] pix_cnt;
      logic [3:0] sub_cnt;
      logic in_line;
      logic clamp;
      logic aux_raw;
      logic [LAMP_CHANNELS-1:0] lamp;
   } state_t;

   state_t st_q;
   state_t st_d;

   // Half-open span test on pixel or slot positions
   function automatic logic in_span(input logic [16:0] val, input logic [16:0] lo,
                                    input logic [16:0] hi);
      in_span = (val >= lo) && (val < hi);
   endfunction

   // Slot pulse inside a dot period: high from rise slot up to fall slot
   function automatic logic slot_on(input logic [3:0] cnt, input logic [3:0] rise,
                                    input logic [3:0] fall);
      slot_on = in_span({13'h0000, cnt}, {13'h0000, rise}, {13'h0000, fall});
   endfunction

   // Read view of one register index
   function automatic logic [31:0] read_reg(input regs_t r, input logic [29:0] idx);
      case (idx)
         IDX_CLAMP_EDGE: read_reg = {16'h0000, r.clamp_edge};
         IDX_LAMP0: read_reg = {16'h0000, r.lamp0};
         IDX_LAMP1: read_reg = {16'h0000, r.lamp1};
         IDX_AUX_CTRL: read_reg = {16'h0000, r.aux_ctrl};
         IDX_CLAMP_SKIP: read_reg = {16'h0000, r.skip};
         IDX_CLAMP_CTRL: read_reg = {16'h0000, r.ctrl};
         default: read_reg = 32'h0000_0000;
      endcase
   endfunction

   // Address decode
   logic addr_hit;
   logic [29:0] idx;
   logic wr_en;
   logic [15:0] wdata;

   always_comb begin
      idx = paddr[31:2];
      case (idx)
         IDX_CLAMP_EDGE, IDX_LAMP0, IDX_LAMP1, IDX_AUX_CTRL, IDX_CLAMP_SKIP,
         IDX_CLAMP_CTRL: addr_hit = (paddr[1:0] == 2'b00);
         default: addr_hit = 1'b0;
      endcase
      wr_en = psel && penable && pwrite && addr_hit;
      wdata = pwdata[15:0];
   end

   // Zero wait state slave; unmapped or unaligned access reports an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;
   assign prdata = st_q.rdata;

   // Decoded active settings
   logic [3:0] clamp_rise;
   logic [3:0] clamp_fall;
   logic [3:0] aux_rise;
   logic [3:0] aux_fall;
   logic aux_guard;
   logic origin_line;
   logic line_scheme;
   logic [16:0] skip_cnt;
   logic [16:0] clamp_len;
   logic [16:0] pix;
   logic [16:0] lead;
   logic [16:0] rel;
   logic [16:0] clamp_lo;
   logic [16:0] clamp_hi;
   logic clamp_window;
   logic clamp_allowed;
   logic in_valid;
   logic [LAMP_EDGE_W-1:0] lamp_lead [LAMP_CHANNELS];
   logic [LAMP_EDGE_W-1:0] lamp_trail [LAMP_CHANNELS];
   logic [LAMP_CHANNELS-1:0] lamp_next;

   always_comb begin
      // R5 clamp rise slot
      clamp_rise = st_q.act.clamp_edge[RISE_LSB +: SLOT_W];
      // R4 clamp fall slot
      clamp_fall = st_q.act.clamp_edge[FALL_LSB +: SLOT_W];
      // R10 aux clock edge slots
      aux_rise = st_q.act.aux_ctrl[RISE_LSB +: SLOT_W];
      aux_fall = st_q.act.aux_ctrl[FALL_LSB +: SLOT_W];
      aux_guard = st_q.act.aux_ctrl[AUX_GUARD_BIT];
      origin_line = st_q.act.skip[SKIP_ORIGIN_BIT];
      line_scheme = st_q.act.ctrl[CTRL_SCHEME_BIT];
      skip_cnt = {3'b000, st_q.act.skip[SKIP_COUNT_LSB +: SKIP_W]};
      // R15 clamp length in pixels
      clamp_len = {10'h000, st_q.act.ctrl[CTRL_LENGTH_LSB +: LENGTH_W]};
      pix = {1'b0, st_q.pix_cnt};
      lead = {1'b0, line_lead_in_delay};
      in_valid = pix >= lead;
      rel = pix - lead;
      // R14 skip origin: line start or first valid pixel
      if (origin_line) begin
         clamp_lo = skip_cnt;
      end else begin
         clamp_lo = lead + skip_cnt;
      end
      clamp_hi = clamp_lo + clamp_len;
      // R3 with origin at line start, a lead-in shorter than skip blocks the clamp
      clamp_allowed = !(origin_line && (lead < skip_cnt));
      // R1 R2 line clamp window; a new line resets the count before it opens
      clamp_window = clamp_allowed && in_span(pix, clamp_lo, clamp_hi);
      // R16 pixel scheme runs all line and ignores skip
      if (!line_scheme) begin
         clamp_window = 1'b1;
      end
      clamp_window = clamp_window && st_q.in_line;
      // R13 per-channel lamp edges relative to end of lead-in
      lamp_lead[0] = st_q.act.lamp0[LAMP_LEAD_LSB +: LAMP_EDGE_W];
      lamp_trail[0] = st_q.act.lamp0[LAMP_TRAIL_LSB +: LAMP_EDGE_W];
      lamp_lead[1] = st_q.act.lamp1[LAMP_LEAD_LSB +: LAMP_EDGE_W];
      lamp_trail[1] = st_q.act.lamp1[LAMP_TRAIL_LSB +: LAMP_EDGE_W];
      for (int i = 0; i < LAMP_CHANNELS; i++) begin
         // R11 R12 R17 envelope between edges in 64-pixel units
         lamp_next[i] = st_q.in_line && in_valid &&
                        in_span(rel, {3'b000, lamp_lead[i], 6'h00},
                                {3'b000, lamp_trail[i], 6'h00});
      end
   end

   // Next state
   always_comb begin
      st_d = st_q;
      // Read data is captured in the setup phase and shown in the access phase
      if (psel && !penable) begin
         // Refused reads return zero, so an unaligned read shows no register
         st_d.rdata = addr_hit ? read_reg(st_q.sw, idx) : 32'h0000_0000;
      end
      // R18 software writes land in the programmed copy
      if (wr_en) begin
         case (idx)
            IDX_CLAMP_EDGE: st_d.sw.clamp_edge = wdata & MASK_CLAMP_EDGE;
            IDX_LAMP0: st_d.sw.lamp0 = wdata & MASK_LAMP;
            IDX_LAMP1: st_d.sw.lamp1 = wdata & MASK_LAMP;
            IDX_AUX_CTRL: st_d.sw.aux_ctrl = wdata & MASK_AUX_CTRL;
            IDX_CLAMP_SKIP: st_d.sw.skip = wdata & MASK_CLAMP_SKIP;
            IDX_CLAMP_CTRL: st_d.sw.ctrl = wdata & MASK_CLAMP_CTRL;
            default: st_d.sw = st_q.sw;
         endcase
      end
      // R18 settings become active at the next line start
      if (line_start) begin
         st_d.act = st_q.sw;
         st_d.pix_cnt = 16'h0000;
         st_d.in_line = scan_enable;
      end else begin
         if (pixel_tick && (st_q.pix_cnt != PIX_CNT_MAX)) begin
            st_d.pix_cnt = st_q.pix_cnt + 16'h0001;
         end
         if (!scan_enable) begin
            st_d.in_line = 1'b0;
         end
      end
      // Dot sub-clock slot counter
      if (dot_start) begin
         st_d.sub_cnt = 4'h0;
      end else if (dot_subclock_divider && (st_q.sub_cnt != SUB_CNT_MAX)) begin
         st_d.sub_cnt = st_q.sub_cnt + 4'h1;
      end
      // R4 R5 clamp shaped inside each dot period
      st_d.clamp = clamp_window && slot_on(st_q.sub_cnt, clamp_rise, clamp_fall);
      // R10 raw aux clock from its slots
      st_d.aux_raw = st_q.in_line && slot_on(st_q.sub_cnt, aux_rise, aux_fall);
      // R9 guard band blanks the slot at each dot period boundary
      if (aux_guard && ((st_q.sub_cnt == 4'h0) || (st_q.sub_cnt == SUB_CNT_MAX))) begin
         st_d.aux_raw = 1'b0;
      end
      st_d.lamp = lamp_next;
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.sw.clamp_edge <= RST_CLAMP_EDGE;
         st_q.sw.lamp0 <= RST_LAMP;
         st_q.sw.lamp1 <= RST_LAMP;
         st_q.sw.aux_ctrl <= RST_AUX_CTRL;
         st_q.sw.skip <= RST_CLAMP_SKIP;
         st_q.sw.ctrl <= RST_CLAMP_CTRL;
         st_q.act.clamp_edge <= RST_CLAMP_EDGE;
         st_q.act.lamp0 <= RST_LAMP;
         st_q.act.lamp1 <= RST_LAMP;
         st_q.act.aux_ctrl <= RST_AUX_CTRL;
         st_q.act.skip <= RST_CLAMP_SKIP;
         st_q.act.ctrl <= RST_CLAMP_CTRL;
      end else begin
         st_q <= st_d;
      end
   end

   // R6 R7 R8 R9 aux clock retiming and pin select
   aux_clock_shaper u_aux_shaper (
      .mclk(mclk),
      .reset_n(reset_n),
      .raw_clk(st_q.aux_raw),
      .sample_in(sample_in),
      .select(st_q.act.aux_ctrl[AUX_SELECT_BIT]),
      .shift(st_q.act.aux_ctrl[AUX_SHIFT_BIT]),
      .delay(st_q.act.aux_ctrl[AUX_DELAY_LSB +: DELAY_W]),
      .invert(st_q.act.aux_ctrl[AUX_INVERT_BIT]),
      .aux_dot_clock(aux_dot_clock)
   );

   assign clamp_out = st_q.clamp;
   assign lamp_envelope_output = st_q.lamp;
endmodule // scan_clamp_led_timing
`default_nettype wire

// file: testbench/scan_timing_assertions.sv
// Checker for APB answers and output timing of the scan timing block.
// Sees only the top module ports; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module scan_timing_assertions (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Strobes and outputs
   input wire logic scan_enable,
   input wire logic line_start,
   input wire logic pixel_tick,
   input wire logic dot_start,
   input wire logic dot_subclock_divider,
   input wire logic sample_in,
   input wire logic clamp_out,
   input wire logic aux_dot_clock,
   input wire logic [scan_timing_pkg::LAMP_CHANNELS-1:0] lamp_envelope_output
);
   import scan_timing_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic sel_pend_q;
   logic sel_act_q;
   logic [1:0] age_q;
   // Shadow of the aux select bit, applied at line start
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sel_pend_q <= 1'h0;
         sel_act_q <= 1'h0;
         age_q <= 2'h0;
      end else begin
         if (psel && penable && pwrite && paddr == {IDX_AUX_CTRL, 2'h0})
            sel_pend_q <= pwdata[AUX_SELECT_BIT];
         if (line_start)
            sel_act_q <= sel_pend_q;
         if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
      end
   end
   ready_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   err_align_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access not refused");
   err_data_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   read_upper_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   clamp_idle_a: assert property (!scan_enable [*3] |-> !clamp_out)
      else $error("clamp active while not scanning");
   lamp_idle_a: assert property (!scan_enable [*3] |-> lamp_envelope_output == '0)
      else $error("lamp active while not scanning");
   lamp_edge_a: assert property ($changed(lamp_envelope_output) |->
      $past(pixel_tick, 2) || $past(line_start, 2) || !$past(scan_enable) || !$past(scan_enable, 2))
      else $error("lamp edge off a pixel boundary");
   clamp_edge_a: assert property ($changed(clamp_out) |->
      $past(dot_start, 2) || $past(dot_subclock_divider, 2) || $past(pixel_tick, 2)
      || $past(line_start, 2) || !$past(scan_enable) || !$past(scan_enable, 2))
      else $error("clamp edge without counter step");
   sample_pass_a: assert property (age_q == 2'h3 && !sel_act_q && !$past(sel_act_q)
      && !$past(sel_act_q, 2) |-> aux_dot_clock == $past(sample_in))
      else $error("aux pin does not carry sample");
endmodule // scan_timing_assertions
bind scan_clamp_led_timing scan_timing_assertions chk (.mclk, .reset_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scan_enable, .line_start,
   .pixel_tick, .dot_start, .dot_subclock_divider, .sample_in, .clamp_out, .aux_dot_clock,
   .lamp_envelope_output);
`default_nettype wire

// file: testbench/sensor_front_model.sv
// Sensor and front-end model: paces scan strobes and measures outputs over one line.
// Assumes the bench asks for one line at a time with a one-cycle go pulse.
`timescale 1ns/1ps
`default_nettype none
module sensor_front_model #(
   parameter int DOTS = 140
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Bench control
   input wire logic go,
   output logic busy,
   // Strobes to the block
   output logic scan_enable,
   output logic line_start,
   output logic pixel_tick,
   output logic dot_start,
   output logic dot_subclock_divider,
   output logic sample_in,
   // Outputs of the block
   input wire logic clamp_out,
   input wire logic aux_dot_clock,
   input wire logic [scan_timing_pkg::LAMP_CHANNELS-1:0] lamp_envelope_output,
   // Measurements, cycles counted from line start
   output logic [15:0] clamp_cnt,
   output logic [15:0] clamp_first,
   output logic [15:0] aux_cnt,
   output logic [15:0] aux_first,
   output logic [15:0] lamp0_cnt,
   output logic [15:0] lamp0_first,
   output logic [15:0] lamp1_cnt
);
   logic [3:0] phase_q;
   logic armed_q;
   logic [15:0] cyc_q;
   // Dot period of sixteen clocks: start, then fifteen sub-clock ticks
   assign dot_start = (phase_q == 4'h0);
   assign pixel_tick = dot_start;
   assign dot_subclock_divider = !dot_start;
   assign sample_in = (phase_q < 4'h3);
   // Line sequencing aligned to the dot phase, and measurement
   always_ff @(posedge mclk) begin
      phase_q <= phase_q + 4'h1;
      line_start <= 1'h0;
      if (!reset_n) begin
         phase_q <= 4'h0;
         armed_q <= 1'h0;
         busy <= 1'h0;
         scan_enable <= 1'h0;
      end else if (go) begin
         armed_q <= 1'h1;
         busy <= 1'h1;
      end else if (armed_q && phase_q == 4'he) begin
         armed_q <= 1'h0;
         line_start <= 1'h1;
         scan_enable <= 1'h1;
         cyc_q <= 16'h0;
         {clamp_cnt, aux_cnt, lamp0_cnt, lamp1_cnt} <= 64'h0;
         {clamp_first, aux_first, lamp0_first} <= 48'hffffffffffff;
      end else if (busy && !armed_q) begin
         cyc_q <= cyc_q + 16'h1;
         clamp_cnt <= clamp_cnt + {15'h0, clamp_out};
         aux_cnt <= aux_cnt + {15'h0, aux_dot_clock};
         lamp0_cnt <= lamp0_cnt + {15'h0, lamp_envelope_output[0]};
         lamp1_cnt <= lamp1_cnt + {15'h0, lamp_envelope_output[1]};
         if (clamp_out && clamp_first == 16'hffff)
            clamp_first <= cyc_q;
         if (aux_dot_clock && aux_first == 16'hffff)
            aux_first <= cyc_q;
         if (lamp_envelope_output[0] && lamp0_first == 16'hffff)
            lamp0_first <= cyc_q;
         if (cyc_q == 16'(16 * DOTS))
            scan_enable <= 1'h0;
         if (cyc_q == 16'(16 * DOTS + 31))
            busy <= 1'h0;
      end
   end
endmodule // sensor_front_model
`default_nettype wire

// file: testbench/tb_scan_clamp_led_timing.sv
// Testbench: APB register checks and per-line output measurements.
// Assumes the sensor model runs 140-dot lines of sixteen clocks per dot.
`timescale 1ns/1ps
`default_nettype none
module tb_scan_clamp_led_timing;
   import scan_timing_pkg::*;
   logic mclk = 1'h0;
   logic reset_n = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic [15:0] line_lead_in_delay = 16'h0;
   logic pready, pslverr, scan_enable, line_start, pixel_tick, dot_start, busy;
   logic dot_subclock_divider, sample_in, clamp_out, aux_dot_clock;
   logic [LAMP_CHANNELS-1:0] lamp_envelope_output;
   logic [15:0] clamp_cnt, clamp_first, aux_cnt, aux_first, lamp0_cnt, lamp0_first, lamp1_cnt;
   logic [29:0] regs [6] = '{IDX_CLAMP_EDGE, IDX_LAMP0, IDX_LAMP1, IDX_AUX_CTRL,
      IDX_CLAMP_SKIP, IDX_CLAMP_CTRL};
   logic [15:0] masks [6] = '{MASK_CLAMP_EDGE, MASK_LAMP, MASK_LAMP, MASK_AUX_CTRL,
      MASK_CLAMP_SKIP, MASK_CLAMP_CTRL};
   int errors = 0;
   int checked = 0;
   // Clock at 200 MHz
   always #2.5 mclk = ~mclk;
   scan_clamp_led_timing dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .scan_enable, .line_start, .line_lead_in_delay, .pixel_tick,
      .dot_start, .dot_subclock_divider, .sample_in, .clamp_out, .aux_dot_clock,
      .lamp_envelope_output);
   sensor_front_model #(.DOTS(140)) afe (.mclk, .reset_n, .go, .busy, .scan_enable,
      .line_start, .pixel_tick, .dot_start, .dot_subclock_divider, .sample_in, .clamp_out,
      .aux_dot_clock, .lamp_envelope_output, .clamp_cnt, .clamp_first, .aux_cnt, .aux_first,
      .lamp0_cnt, .lamp0_first, .lamp1_cnt);
   // Print counts and verdict, then stop
   task automatic test_done;
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Compare bus data or a response flag
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Compare a measured cycle count or position
   task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; checks the refusal flag and, on reads, the data
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
      input logic eerr, input logic [31:0] exp);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'h1;
      @(posedge mclk);
      while (pready !== 1'h1 && n < 20) begin
         n++;
         @(posedge mclk);
      end
      if (n >= 20)
         errors++;
      chk_reg({31'h0, pslverr}, {31'h0, eerr}); // refusal
      if (!w)
         chk_reg(prdata, exp); // read data
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Ask the model for one line and wait until it is measured
   task automatic line;
      int n;
      n = 0;
      @(posedge mclk);
      go <= 1'h1;
      @(posedge mclk);
      go <= 1'h0;
      @(posedge mclk);
      while (busy === 1'h1 && n < 5000) begin
         n++;
         @(posedge mclk);
      end
      if (n >= 5000)
         errors++;
   endtask
   // Program one setting, run two lines, check the second
   task automatic run_cfg(input logic [15:0] lead, input logic [15:0] ctrl,
      input logic [15:0] skip, input logic [15:0] aux, input logic [15:0] cc,
      input logic [15:0] cf, input logic [15:0] ac, input logic [15:0] af);
      apb(1'h1, {IDX_CLAMP_CTRL, 2'h0}, {16'h0, ctrl}, 1'h0, 32'h0);
      apb(1'h1, {IDX_CLAMP_SKIP, 2'h0}, {16'h0, skip}, 1'h0, 32'h0);
      apb(1'h1, {IDX_AUX_CTRL, 2'h0}, {16'h0, aux}, 1'h0, 32'h0);
      line_lead_in_delay <= lead;
      line();
      line();
      chk_cnt(clamp_cnt, cc); // cycles held
      chk_cnt(clamp_first, cf); // first edge
      chk_cnt(aux_cnt, ac); // width
      chk_cnt(aux_first, af); // position
      chk_cnt(lamp0_cnt, 16'h0400); // envelope
      chk_cnt(lamp0_first, 16'h10 * (lead + 16'h40) - 16'hd); // lead-in
      chk_cnt(lamp1_cnt, 16'h0800); // own channel
   endtask
   // Watchdog
   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      test_done();
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge mclk);
      reset_n <= 1'h1;
      for (int i = 0; i < 6; i++) begin
         apb(1'h0, {regs[i], 2'h0}, 32'h0, 1'h0, 32'h0); // reset
         apb(1'h1, {regs[i], 2'h0}, 32'hffffffff, 1'h0, 32'h0); // write
         apb(1'h0, {regs[i], 2'h0}, 32'h0, 1'h0, {16'h0, masks[i]}); // read back
      end
      apb(1'h0, 32'h0, 32'h0, 1'h1, 32'h0); // unmapped
      apb(1'h1, {IDX_LAMP0, 2'h1}, 32'h0, 1'h1, 32'h0); // misaligned
      apb(1'h0, {IDX_LAMP0, 2'h2}, 32'h0, 1'h1, 32'h0); // misaligned read
      apb(1'h0, {IDX_LAMP0, 2'h0}, 32'h0, 1'h0, 32'h0000ffff); // kept
      apb(1'h1, {IDX_LAMP0, 2'h0}, 32'h0201, 1'h0, 32'h0);
      apb(1'h1, {IDX_LAMP1, 2'h0}, 32'h0200, 1'h0, 32'h0);
      apb(1'h1, {IDX_CLAMP_EDGE, 2'h0}, 32'h0092, 1'h0, 32'h0);
      run_cfg(16'h1, 16'h8003, 16'h0002, 16'h8092, 16'h15, 16'h25, 16'h3d4, 16'h7);
      run_cfg(16'h4, 16'h8003, 16'h8002, 16'h9c92, 16'h15, 16'h15, 16'h3d4, 16'hb);
      run_cfg(16'h1, 16'h8003, 16'h8002, 16'h8292, 16'h0, 16'hffff, 16'h50c, 16'h0);
      run_cfg(16'h1, 16'h8003, 16'h00c8, 16'h0092, 16'h0, 16'hffff, 16'h1aa, 16'h2);
      run_cfg(16'h1, 16'h0003, 16'h80c8, 16'h81f0, 16'h3d4, 16'h5, 16'h7a8, 16'h6);
      test_done();
   end
endmodule // tb_scan_clamp_led_timing
`default_nettype wire
